/* rtl/i2csf_pkg.sv */
// constants shared by the serial bus status-flag block
package i2csf_pkg;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam int          AXI_AW       = 5;
	localparam logic [4:0]  OFS_STATUS   = 5'h00;
	localparam logic [4:0]  OFS_CTRL     = 5'h04;
	localparam logic [4:0]  OFS_ADDR     = 5'h08;
	localparam logic [4:0]  OFS_DATA     = 5'h0C;
	localparam logic [4:0]  OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0]  OFS_IRQ_MASK = 5'h14;

	// ****************************************
	// bus_status_register fields
	// ****************************************
	localparam int          BIT_ERR_END  = 7;
	localparam int          BIT_NRM_END  = 6;
	localparam int          BIT_CONT_IRQ = 5;
	localparam int          BIT_SEC_HIT  = 4;
	localparam int          BIT_ARB_LOSS = 3;
	localparam int          BIT_OWN_HIT  = 2;
	localparam int          BIT_GEN_CALL = 1;
	localparam int          BIT_ACK      = 0;
	localparam logic [7:0]  STATUS_RST   = 8'h00;

	// ****************************************
	// control and address register fields
	// ****************************************
	localparam int          CTL_MASTER   = 0;
	localparam int          CTL_TX       = 1;
	localparam int          CTL_SERIAL   = 2;
	localparam int          CTL_FSX      = 3;
	localparam int          CTL_IRQF     = 4;
	localparam int          ADDR2_LSB    = 8;

	// ****************************************
	// frame and bus answers
	// ****************************************
	localparam logic [3:0]  FRAME_BITS   = 4'h8;
	localparam logic [7:0]  GEN_CALL     = 8'h00;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* rtl/i2csf_sync.sv */
// two-stage synchroniser for the bus pins
`timescale 1ns/1ns
module i2csf_sync
	import i2csf_pkg::*;
#(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_rstn,
	// asynchronous inputs and synchronised copies
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} i2csf_sync_t;

	i2csf_sync_t q;
	i2csf_sync_t d;

	// only the second stage is visible to logic
	always_comb begin
		d      = q;
		d.meta = i_d;
		d.held = q.meta;
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			// pins idle high behind their pull-ups
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign o_q = q.held;

endmodule

/* rtl/i2csf_flag.sv */
// one sticky status flag, set beats clear
`timescale 1ns/1ns
module i2csf_flag
	import i2csf_pkg::*;
(
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	// events
	input  wire logic i_set,
	input  wire logic i_clr,
	// flag
	output logic      o_q
);

	typedef struct packed {
		logic flag;
	} i2csf_flag_t;

	i2csf_flag_t q;
	i2csf_flag_t d;

	// an event in the clearing cycle must not be lost
	always_comb begin
		d = q;
		if (i_set) begin
			d.flag = 1'b1;
		end else if (i_clr) begin
			d.flag = 1'b0;
		end
	end

	// every flag comes out of reset clear
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_q = q.flag;

endmodule

/* rtl/i2csf_top.sv */
// serial bus status-flag logic with register slave
//
// Contract
// - status register eight bits, reset zero
// - bits 7..1 clear-only, ack bit free
// - zero write after reading one clears
// - stop mid-frame sets error-end flag
// - error-end clears by write or irq-clear
// - stop after frame sets normal-end flag
// - tx-empty/rx-full sets continuous flag
// - continuous flag also sets interface irq
// - interface irq clear drops continuous flag
// - first byte equals second address field
// - second match cleared by start, master
// - data pin mismatch at clock rise
// - internal clock high at bus fall
// - data access clears arbitration loss
// - first byte own address or general call
// - data access clears own match flag
// - ack captured in tx, driven in rx
// - ack read source follows transmit select
`timescale 1ns/1ns
module i2csf_top
	import i2csf_pkg::*;
(
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rstn,
	// axi4-lite write
	input  wire logic [AXI_AW-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	// axi4-lite read
	input  wire logic [AXI_AW-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	// bus pins
	input  wire logic              i_scl,
	input  wire logic              i_sda,
	output logic                   o_sda_out,
	output logic                   o_sda_oe,
	// transfer engine
	input  wire logic              i_int_sda,
	input  wire logic              i_int_scl,
	input  wire logic              i_tx_empty_set,
	input  wire logic              i_rx_full_set,
	output logic [7:0]             o_tx_data,
	output logic                   o_tx_load,
	// interrupt
	output logic                   o_irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic              aw_held;
		logic [AXI_AW-1:0] aw_addr;
		logic              w_held;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [3:0]        ctrl;
		logic              interface_irq_flag;
		logic [6:0]        addr1;
		logic [6:0]        addr2;
		logic              ack_sw;
		logic              ack_bus;
		logic [7:0]        shift;
		logic [7:0]        rx_byte;
		logic [7:0]        tx_byte;
		logic              tx_load;
		logic [3:0]        bit_cnt;
		logic              first;
		logic              addressed;
		logic              ack_drv;
		logic              scl_d;
		logic              sda_d;
		logic [7:1]        armed;
		logic [7:1]        irq_stat;
		logic [7:1]        irq_mask;
	} i2csf_state_t;

	i2csf_state_t q;
	i2csf_state_t d;

	logic [1:0] pin_s;
	logic       scl_s;
	logic       sda_s;
	logic [7:1] flag;
	logic [7:1] set_vec;
	logic [7:1] clr_vec;
	logic [7:1] sw_clr;

	// ****************************************
	// pin sampling and bus events
	// ****************************************
	i2csf_sync #(
		.W (2)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_d       ({i_scl, i_sda}),
		.o_q       (pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	logic scl_rise;
	logic scl_fall;
	logic start_evt;
	logic stop_evt;
	assign scl_rise  = scl_s & ~q.scl_d;
	assign scl_fall  = ~scl_s & q.scl_d;
	assign start_evt = scl_s & q.scl_d & q.sda_d & ~sda_s;
	assign stop_evt  = scl_s & q.scl_d & ~q.sda_d & sda_s;

	logic master;
	logic tx;
	logic addr_fmt;
	logic second_format_select;
	assign master   = q.ctrl[CTL_MASTER];
	assign tx       = q.ctrl[CTL_TX];
	assign addr_fmt = ~q.ctrl[CTL_SERIAL];
	assign second_format_select      = q.ctrl[CTL_FSX];

	logic [7:0] byte_now;
	logic       byte_end;
	logic       ack_rise;
	logic       slv_first;
	logic       gc_hit;
	logic       own_hit;
	logic       sec_hit;
	assign byte_now  = {q.shift[6:0], sda_s};
	assign byte_end  = scl_rise & (q.bit_cnt == FRAME_BITS - 4'h1);
	assign ack_rise  = scl_rise & (q.bit_cnt == FRAME_BITS);
	assign slv_first = byte_end & q.first & ~master & ~tx & addr_fmt;
	assign gc_hit    = byte_now == GEN_CALL;
	// own address or general call on first byte
	assign own_hit   = slv_first & ((byte_now[7:1] == q.addr1) | gc_hit);
	// second address only with second format select low
	assign sec_hit   = slv_first & ~second_format_select & (byte_now[7:1] == q.addr2);

	// ****************************************
	// flag set and clear terms
	// ****************************************
	logic al_set;
	logic continuous_transfer_irq_flag_set;
	logic error_end_flag_set;
	logic nstp_set;
	logic slv_stop;
	// pin disagrees with driven data at clock rise
	// own clock still high when the bus clock falls
	assign al_set   = master & tx & ((scl_rise & (i_int_sda != sda_s)) | (scl_fall & i_int_scl));
	// slave mode needs the second match
	assign continuous_transfer_irq_flag_set = (i_tx_empty_set | i_rx_full_set) & (master | flag[BIT_SEC_HIT]);
	assign slv_stop = stop_evt & ~master & addr_fmt;
	// bits pending beyond the stop's own clock rise
	assign error_end_flag_set = slv_stop & (q.bit_cnt > 4'h1);
	// only the stop's own clock rise since the frame ended
	assign nstp_set = slv_stop & (q.bit_cnt <= 4'h1);

	assign set_vec = {error_end_flag_set, nstp_set, continuous_transfer_irq_flag_set, sec_hit, al_set, own_hit, own_hit & gc_hit};

	logic [AXI_AW-1:0] wa;
	logic              wr_fire;
	logic              wr_lane0;
	logic              wr_st;
	logic              wr_ctrl;
	logic              wr_data;
	logic              rd_fire;
	logic              rd_st;
	logic              rd_data;
	assign wa       = q.aw_addr;
	assign wr_fire  = q.aw_held & q.w_held & ~q.bvalid;
	assign wr_lane0 = wr_fire & q.w_strb[0];
	assign wr_st    = wr_lane0 & (wa == OFS_STATUS);
	assign wr_ctrl  = wr_lane0 & (wa == OFS_CTRL);
	assign wr_data  = wr_lane0 & (wa == OFS_DATA);
	assign rd_fire  = i_arvalid & ~q.rvalid;
	assign rd_st    = rd_fire & (i_araddr == OFS_STATUS);
	assign rd_data  = rd_fire & (i_araddr == OFS_DATA);

	logic interface_irq_flag_set;
	logic interface_irq_flag_clr;
	logic data_clr;
	// every flag event raises the interface irq flag
	assign interface_irq_flag_set = |set_vec;
	assign interface_irq_flag_clr = wr_ctrl & ~q.w_data[CTL_IRQF] & q.interface_irq_flag & ~interface_irq_flag_set;
	assign data_clr = (wr_data & tx) | (rd_data & ~tx);

	// a zero clears only what was read as one
	// writing one leaves the flag alone
	assign sw_clr = {7{wr_st}} & ~q.w_data[7:1] & q.armed;

	// error-end also dropped with the irq flag
	assign clr_vec[BIT_ERR_END]  = sw_clr[BIT_ERR_END] | interface_irq_flag_clr;
	// normal-end also dropped with the irq flag
	assign clr_vec[BIT_NRM_END]  = sw_clr[BIT_NRM_END] | interface_irq_flag_clr;
	// continuous flag follows the irq flag clear
	assign clr_vec[BIT_CONT_IRQ] = sw_clr[BIT_CONT_IRQ] | interface_irq_flag_clr;
	// start clears, master mode holds clear
	assign clr_vec[BIT_SEC_HIT]  = sw_clr[BIT_SEC_HIT] | start_evt | master;
	// data register access clears arbitration loss
	assign clr_vec[BIT_ARB_LOSS] = sw_clr[BIT_ARB_LOSS] | data_clr;
	// data register access clears own match
	assign clr_vec[BIT_OWN_HIT]  = sw_clr[BIT_OWN_HIT] | data_clr | master;
	assign clr_vec[BIT_GEN_CALL] = sw_clr[BIT_GEN_CALL] | data_clr | master;

	// bits seven to one move only through set and clear terms
	for (genvar b = 1; b < 8; b++) begin : g_flag
		i2csf_flag u_flag (
			.i_ref_clk (i_ref_clk),
			.i_rstn    (i_rstn),
			.i_set     (set_vec[b]),
			.i_clr     (clr_vec[b]),
			.o_q       (flag[b])
		);
	end

	// ****************************************
	// register read data
	// ****************************************
	logic [7:0]  status_rd;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        ack_rd;
	// transmit select picks captured or written ack
	assign ack_rd    = tx ? q.ack_bus : q.ack_sw;
	assign status_rd = {flag, ack_rd};

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (i_araddr)
			OFS_STATUS:   rd_word[7:0] = status_rd;
			OFS_CTRL:     rd_word[4:0] = {q.interface_irq_flag, q.ctrl};
			OFS_ADDR:     rd_word[14:0] = {q.addr2, 1'b0, q.addr1};
			OFS_DATA:     rd_word[7:0] = q.rx_byte;
			OFS_IRQ_STAT: rd_word[7:0] = {q.irq_stat, 1'b0};
			OFS_IRQ_MASK: rd_word[7:0] = {q.irq_mask, 1'b0};
			default:      rd_ok = 1'b0;
		endcase
	end

	logic wr_ok;
	assign wr_ok = (wa == OFS_STATUS) | (wa == OFS_CTRL) | (wa == OFS_ADDR) |
	               (wa == OFS_DATA) | (wa == OFS_IRQ_STAT) | (wa == OFS_IRQ_MASK);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d         = q;
		d.scl_d   = scl_s;
		d.sda_d   = sda_s;
		d.tx_load = 1'b0;

		if (i_awvalid && o_awready) begin
			d.aw_held = 1'b1;
			d.aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			d.w_held = 1'b1;
			d.w_data = i_wdata;
			d.w_strb = i_wstrb;
		end
		if (q.bvalid && i_bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			d.aw_held = 1'b0;
			d.w_held  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (q.rvalid && i_rready) begin
			d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			d.rvalid = 1'b1;
			d.rdata  = rd_word;
			d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// register writes, low byte lane except addr2 on lane one
		if (wr_st) begin
			d.ack_sw = q.w_data[BIT_ACK];
		end
		if (wr_ctrl) begin
			d.ctrl = q.w_data[3:0];
		end
		if (wr_fire && (wa == OFS_ADDR)) begin
			if (q.w_strb[0]) begin
				d.addr1 = q.w_data[6:0];
			end
			if (q.w_strb[1]) begin
				d.addr2 = q.w_data[ADDR2_LSB +: 7];
			end
		end
		if (wr_data) begin
			d.tx_byte = q.w_data[7:0];
			d.tx_load = 1'b1;
		end
		if (wr_lane0 && (wa == OFS_IRQ_MASK)) begin
			d.irq_mask = q.w_data[7:1];
		end
		// events win over a write-one-to-clear
		d.irq_stat = q.irq_stat;
		if (wr_lane0 && (wa == OFS_IRQ_STAT)) begin
			d.irq_stat = q.irq_stat & ~q.w_data[7:1];
		end
		d.irq_stat = d.irq_stat | set_vec;

		if (interface_irq_flag_set) begin
			d.interface_irq_flag = 1'b1;
		end else if (interface_irq_flag_clr) begin
			d.interface_irq_flag = 1'b0;
		end

		// arm bits seen as one by a status read
		d.armed = (q.armed | ({7{rd_st}} & flag)) & ~clr_vec;

		// frame tracking on the sampled pins
		if (start_evt || stop_evt) begin
			d.bit_cnt   = 4'h0;
			d.first     = start_evt;
			d.addressed = 1'b0;
			d.ack_drv   = 1'b0;
		end else if (scl_rise) begin
			if (q.bit_cnt < FRAME_BITS) begin
				d.shift   = byte_now;
				d.bit_cnt = 4'(q.bit_cnt + 4'h1);
			end else begin
				d.bit_cnt = 4'h0;
				d.first   = 1'b0;
			end
			if (byte_end && !tx) begin
				d.rx_byte = byte_now;
			end
			// receiver's answer lands in the captured ack
			if (ack_rise && tx) begin
				d.ack_bus = sda_s;
			end
			if (own_hit || sec_hit) begin
				d.addressed = 1'b1;
			end
		end else if (scl_fall) begin
			// drive the written ack over the ninth clock
			d.ack_drv = (q.bit_cnt == FRAME_BITS) & ~tx & addr_fmt & (master | q.addressed);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '0;
			// bus lines idle high, so no false edge follows reset
			q.scl_d <= 1'b1;
			q.sda_d <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_awready = ~q.aw_held & ~q.bvalid;
	assign o_wready  = ~q.w_held & ~q.bvalid;
	assign o_bvalid  = q.bvalid;
	assign o_bresp   = q.bresp;
	assign o_arready = ~q.rvalid;
	assign o_rvalid  = q.rvalid;
	assign o_rdata   = q.rdata;
	assign o_rresp   = q.rresp;
	// open drain: only a low level is ever driven
	assign o_sda_out = 1'b0;
	assign o_sda_oe  = q.ack_drv & ~q.ack_sw;
	assign o_tx_data = q.tx_byte;
	assign o_tx_load = q.tx_load;
	assign o_irq     = |(q.irq_stat & q.irq_mask);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	sequence wr_taken_s;
		wr_fire;
	endsequence
	sequence resp_up_s;
		##1 o_bvalid;
	endsequence

	write_resp_a: assert property (wr_taken_s |-> resp_up_s)
		else $error("write response missing");
	// continuous flag and irq flag rise together
	cont_irq_a: assert property (continuous_transfer_irq_flag_set |=> flag[BIT_CONT_IRQ] && q.interface_irq_flag)
		else $error("continuous flag without irq flag");
	irq_drop_a: assert property (interface_irq_flag_clr && set_vec[7:5] == 3'b000 |=>
		flag[7:5] == 3'b000 && !q.interface_irq_flag)
		else $error("irq clear left stop or continuous flag");
	sec_master_a: assert property (master [*2] |-> !flag[BIT_SEC_HIT])
		else $error("second match set in master mode");
	sec_start_a: assert property (start_evt && !sec_hit |=> !flag[BIT_SEC_HIT])
		else $error("second match survived start");
	arb_set_a: assert property (al_set |=> flag[BIT_ARB_LOSS] && q.interface_irq_flag)
		else $error("arbitration loss not flagged");
	data_clr_a: assert property (data_clr && !al_set && !own_hit |=>
		flag[3:1] == 3'b000)
		else $error("data access left match or loss flag");
	zero_clr_a: assert property (sw_clr[BIT_ERR_END] && !error_end_flag_set |=>
		!flag[BIT_ERR_END])
		else $error("armed zero write did not clear");
	one_keep_a: assert property (wr_st && q.armed == 7'h00 && set_vec == 7'h00 &&
		clr_vec == 7'h00 |=> flag == $past(flag))
		else $error("unarmed status write changed a flag");
	ack_read_a: assert property (rd_st |=> o_rdata[BIT_ACK] ==
		$past(ack_rd))
		else $error("ack bit read from wrong source");
	stop_kind_a: assert property (slv_stop |=> flag[BIT_ERR_END] || flag[BIT_NRM_END])
		else $error("slave stop not flagged");

endmodule

/* tb/i2csf_bus_model.sv */
// two-wire bus partner: drives the clock and pulls the data line
`timescale 1ns/1ns
module i2csf_bus_model (
	// clock
	input  wire logic i_ref_clk,
	// bus lines
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// quarter of the 400 ns link period; clock stands high outside frames
	task automatic wq(input int n);
		repeat (2 * n) @(posedge i_ref_clk);
	endtask
	task automatic start();
		wq(1);
		o_sda_low <= 1'b0;
		wq(1);
		o_scl <= 1'b1;
		wq(2);
		o_sda_low <= 1'b1;
		wq(2);
		o_scl <= 1'b0;
	endtask
	task automatic stop();
		wq(1);
		o_sda_low <= 1'b1;
		wq(1);
		o_scl <= 1'b1;
		wq(2);
		o_sda_low <= 1'b0;
		wq(2);
	endtask
	task automatic bit_io(input logic b, output logic s);
		wq(1);
		o_sda_low <= !b;
		wq(1);
		o_scl <= 1'b1;
		wq(1);
		s = i_sda;
		wq(1);
		o_scl <= 1'b0;
	endtask
	// ack sampled with the line released
	task automatic byte_io(input logic [7:0] d, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, a);
	endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the status-flag block
`timescale 1ns/1ns
module tb;
	import i2csf_pkg::*;
	logic              clk = 0, rstn = 0;
	logic [AXI_AW-1:0] awaddr = 0, araddr = 0;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0]       wdata = 0, rdata, v;
	logic [3:0]        wstrb = 0;
	logic              awready, wready, bvalid, arready, rvalid, sda_out, sda_oe, tx_load, irq;
	logic [1:0]        bresp, rresp, r;
	logic [7:0]        tx_data;
	logic              int_sda = 0, int_scl = 0, txe = 0, rxf = 0, scl, sda_low, a;
	wire               sda;
	int                error_cnt = 0, n_compared = 0;
	// pull-up: low while either party pulls
	assign sda = (sda_low | sda_oe) ? 1'b0 : 1'b1;
	always #25 clk = ~clk;
	int                n_load = 0;
	always @(posedge clk) if (tx_load) n_load++;
	i2csf_top i2csf_top_i (.i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_int_sda(int_sda), .i_int_scl(int_scl), .i_tx_empty_set(txe),
		.i_rx_full_set(rxf), .o_tx_data(tx_data), .o_tx_load(tx_load), .o_irq(irq));
	i2csf_bus_model i2csf_bus_model_i (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low));
	// ****************************************
	// bus tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		logic aw, w, b;
		@(posedge clk);
		awaddr <= ad;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge clk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
			if (b) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [4:0] ad);
		logic ar, b;
		@(posedge clk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge clk);
			ar = arvalid & arready;
			b = rvalid;
			v = rdata;
			r = rresp;
			@(posedge clk);
			if (ar)
				arvalid <= 1'b0;
			if (b) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rchk(input string n, input logic [4:0] ad, input logic [31:0] e);
		rd(ad);
		chk(n, e, v);
	endtask
	task automatic pulse_txe();
		@(posedge clk);
		txe <= 1'b1;
		@(posedge clk);
		txe <= 1'b0;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_ack_tx();
		rchk("status rst", OFS_STATUS, 32'h00);
		wr(OFS_CTRL, 32'h02);
		i2csf_bus_model_i.start();
		i2csf_bus_model_i.byte_io(8'h00, a);
		rchk("bus ack", OFS_STATUS, 32'h01);
		wr(OFS_CTRL, 32'h00);
		rchk("soft ack", OFS_STATUS, 32'h00);
	endtask
	task automatic t_own();
		wr(OFS_ADDR, 32'h152A);
		i2csf_bus_model_i.start();
		i2csf_bus_model_i.byte_io(8'h54, a);
		chk("ack out", 0, a);
		chk("irq masked", 0, irq);
		chk("sda out", 0, sda_out);
		wr(OFS_STATUS, 32'h00);
		rchk("no arm", OFS_STATUS, 32'h04);
		wr(OFS_STATUS, 32'hFE);
		rchk("ones keep", OFS_STATUS, 32'h04);
		wr(OFS_STATUS, 32'h00);
		rchk("cleared", OFS_STATUS, 32'h00);
		wr(OFS_STATUS, 32'h01);
		rchk("ack rw", OFS_STATUS, 32'h01);
		wr(OFS_STATUS, 32'h00);
		pulse_txe();
		rchk("no cont", OFS_STATUS, 32'h00);
		wr(OFS_IRQ_MASK, 32'h04);
		chk("irq on", 1, irq);
		wr(OFS_IRQ_STAT, 32'h04);
		chk("irq off", 0, irq);
	endtask
	task automatic t_gen_call();
		i2csf_bus_model_i.start();
		i2csf_bus_model_i.byte_io(8'h00, a);
		rchk("gen call", OFS_STATUS, 32'h06);
		rd(OFS_DATA);
		rchk("data rd", OFS_STATUS, 32'h00);
	endtask
	task automatic t_second();
		i2csf_bus_model_i.start();
		i2csf_bus_model_i.byte_io(8'h2A, a);
		rchk("sec hit", OFS_STATUS, 32'h10);
		wr(OFS_CTRL, 32'h00);
		rchk("irqf off", OFS_CTRL, 32'h00);
		pulse_txe();
		rchk("cont set", OFS_STATUS, 32'h30);
		rchk("irqf set", OFS_CTRL, 32'h10);
		wr(OFS_CTRL, 32'h00);
		rchk("cont clr", OFS_STATUS, 32'h10);
	endtask
	task automatic t_stops();
		logic s;
		i2csf_bus_model_i.start();
		rchk("start clr", OFS_STATUS, 32'h00);
		repeat (3) i2csf_bus_model_i.bit_io(1'b1, s);
		i2csf_bus_model_i.stop();
		rchk("err stop", OFS_STATUS, 32'h80);
		wr(OFS_CTRL, 32'h00);
		rchk("err clr", OFS_STATUS, 32'h00);
		i2csf_bus_model_i.start();
		i2csf_bus_model_i.byte_io(8'hFE, a);
		i2csf_bus_model_i.stop();
		rchk("nrm stop", OFS_STATUS, 32'h40);
		wr(OFS_CTRL, 32'h00);
		rchk("nrm clr", OFS_STATUS, 32'h00);
	endtask
	task automatic t_arb();
		logic s;
		wr(OFS_CTRL, 32'h03);
		i2csf_bus_model_i.start();
		int_sda <= 1'b1;
		i2csf_bus_model_i.bit_io(1'b0, s);
		rd(OFS_STATUS);
		chk("arb data", 32'h08, v & 32'hFE);
		wr(OFS_DATA, 32'h5A);
		chk("tx data", 32'h5A, tx_data);
		rd(OFS_STATUS);
		chk("arb wr clr", 32'h00, v & 32'hFE);
		chk("tx load", 1, n_load);
		int_scl <= 1'b1;
		i2csf_bus_model_i.bit_io(1'b1, s);
		// hold the internal clock until the fall has crossed the synchroniser
		repeat (4) @(posedge clk);
		int_scl <= 1'b0;
		rd(OFS_STATUS);
		chk("arb clk", 32'h08, v & 32'hFE);
		wr(OFS_CTRL, 32'h00);
		rd(OFS_DATA);
		rchk("arb rd clr", OFS_STATUS, 32'h00);
	endtask
	task automatic t_map();
		wr(5'h18, 32'h01);
		chk("wr resp", RESP_SLVERR, r);
		rd(5'h18);
		chk("rd resp", RESP_SLVERR, r);
		chk("rd data", 0, v);
	endtask
	// ****************************************
	// run control
	// ****************************************
	task automatic summarize();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_ack_tx();
		t_own();
		t_gen_call();
		t_second();
		t_stops();
		t_arb();
		t_map();
		summarize();
	end
	// the run needs well under 5000 cycles
	initial begin
		#500000;
		error_cnt++;
		summarize();
	end
endmodule
